/* tef_consts.svh */
/*
 * constants of the transaction event flags block: offsets, bit positions,
 * reset values and error tags. assumes inclusion by bare name.
 */
// What this block does
// - slave op addressed to us finished sets the slave-done flag, bit 20.
// - while slave-done pends, stretch clock low, withhold slave notices and master starts.
// - lost arbitration sets flag bit 24 and records an arbitration error tag unless a bus error comes in the same cycle.
// - releasing data high but seeing low: stop, leave bus, await STOP, retry.
// - the station first driving a lone zero wins arbitration.
// - unexpected START or STOP mid-transfer sets bit 25, tags it, action per operation.
// - master transfer finished without stop request sets flag bit 28.
// - finish without stop: no STOP driven, clock stretched, slave notices withheld until clear.
// - writing one to a clear bit clears its event; zero leaves it; raw is read-only.
// - masked status register sits at offset 0x34 beside raw status.
`ifndef TEF_CONSTS_SVH
`define TEF_CONSTS_SVH

`define TEF_OFS_RAW 8'h30
`define TEF_OFS_MASKED 8'h34
`define TEF_OFS_CLEAR 8'h38
`define TEF_OFS_STATUS 8'h3c
`define TEF_OFS_MASK 8'h40

`define TEF_BIT_SLV_DONE 20
`define TEF_BIT_ARB_LOST 24
`define TEF_BIT_BUS_ERR 25
`define TEF_BIT_MST_NOSTOP 28
`define TEF_IMPL_BITS 32'h1310_0000

`define TEF_RST_RAW 32'h0000_0000
`define TEF_RST_MASK 32'h0000_0000
`define TEF_TAG_W 4
`define TEF_TAG_NONE 4'h0
`define TEF_TAG_ARB_LOST 4'h1
`define TEF_TAG_BUS_ERR 4'h2

`endif

/* tef_pkg.sv */
/*
 * types of the transaction event flags block.
 * assumes nothing of its surroundings.
 */
`default_nettype none
package tef_pkg;
    // wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } tef_wb_req_s;

    // events and levels from the controller core, same clock
    typedef struct packed {
        logic slv_done;
        logic mst_done;
        logic mst_stop_req;
        logic mst_release_hi;
        logic mst_active;
        logic slv_active;
    } tef_core_evt_s;

    typedef enum logic [1:0] {
        ARB_IDLE,
        ARB_WAIT_STOP,
        ARB_RETRY
    } tef_arb_e;
endpackage
`default_nettype wire

/* tef_bus_cond.sv */
/*
 * two-wire line synchroniser with start and stop detection.
 * assumes scl and sda pins come from outside the clock domain.
 */
`default_nettype none
module tef_bus_cond
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    // raw pins
    input wire logic scl_in,
    input wire logic sda_in,
    // conditioned lines
    output logic scl_sync,
    output logic sda_sync,
    output logic start_det,
    output logic stop_det
);
    import tef_pkg::*;

    logic [1:0] meta_ff, nxt_meta;
    logic [1:0] sync_ff, nxt_sync;
    logic [1:0] prev_ff, nxt_prev;
    logic start_ff, nxt_start;
    logic stop_ff, nxt_stop;

    // meta stage feeds only the sync stage
    always_comb
    begin
        nxt_meta = {scl_in, sda_in};
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
        nxt_start = sync_ff[1] && prev_ff[1] && prev_ff[0] && !sync_ff[0];
        nxt_stop = sync_ff[1] && prev_ff[1] && !prev_ff[0] && sync_ff[0];
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_ff <= 2'h3;
            sync_ff <= 2'h3;
            prev_ff <= 2'h3;
            start_ff <= 1'b0;
            stop_ff <= 1'b0;
        end
        else if (ce)
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
            start_ff <= nxt_start;
            stop_ff <= nxt_stop;
        end
    end

    assign scl_sync = sync_ff[1];
    assign sda_sync = sync_ff[0];
    assign start_det = start_ff;
    assign stop_det = stop_ff;
endmodule // tef_bus_cond
`default_nettype wire

/* tef_event_flags.sv */
/*
 * transaction event flags: raw and masked event status, clear, mask,
 * error tag, clock stretching, arbitration loss and retry, bus errors.
 * assumes a classic wishbone master and a controller core on sys_clk.
 */
// The Wishbone slave port was decided locally.
`include "tef_consts.svh"
`default_nettype none
module tef_event_flags
(
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    // wishbone slave
    input wire tef_pkg::tef_wb_req_s wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // controller core
    input wire tef_pkg::tef_core_evt_s core_evt,
    output logic mst_start_ok,
    output logic slv_notify_ok,
    output logic stop_inhibit,
    output logic mst_leave_bus,
    output logic mst_retry,
    output logic bus_error_flag_mst_abort,
    output logic bus_error_flag_slv_abort,
    output logic [3:0] error_tag,
    // two-wire pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    // interrupt
    output logic irq
);
    import tef_pkg::*;

    // flag bits that exist; all others stay zero
    localparam logic [31:0] impl_bits = `TEF_IMPL_BITS;
    logic scl_s, sda_s, start_det, stop_det;
    logic [31:0] raw_ff, mask_ff, nxt_mask;
    wire logic [31:0] nxt_raw;
    logic [31:0] set_vec, clr_vec, masked, rd_mux;
    logic [31:0] dat_ff, nxt_dat;
    logic ack_ff, nxt_ack;
    logic wr_commit, arb_set, bus_error_flag_set;
    logic [3:0] tag_ff, nxt_tag;
    logic stretch_ff, nxt_stretch;
    logic mabort_ff, nxt_mabort, sabort_ff, nxt_sabort;
    tef_arb_e arb_ff, nxt_arb;

    tef_bus_cond u_cond
    (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .ce(ce),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_sync(scl_s),
        .sda_sync(sda_s),
        .start_det(start_det),
        .stop_det(stop_det)
    );

    // bus access: ack one cycle after request, write at the ack edge
    assign nxt_ack = wb_req.cyc && wb_req.stb && !ack_ff;
    assign wr_commit = wb_req.cyc && wb_req.stb && wb_req.we && ack_ff;

    assign masked = raw_ff & mask_ff;

    always_comb
    begin
        unique case (wb_req.adr)
            `TEF_OFS_RAW: rd_mux = raw_ff;
            `TEF_OFS_MASKED: rd_mux = masked;
            `TEF_OFS_MASK: rd_mux = mask_ff;
            `TEF_OFS_STATUS: rd_mux = {28'h000_0000, tag_ff};
            default: rd_mux = 32'h0000_0000;
        endcase
        nxt_dat = nxt_ack ? rd_mux : 32'h0000_0000;
    end

    // we released high yet see low while clock high
    assign arb_set = core_evt.mst_release_hi && scl_s && !sda_s && (arb_ff == ARB_IDLE);
    // start or stop inside a transfer
    assign bus_error_flag_set = (start_det || stop_det) && (core_evt.mst_active || core_evt.slv_active);

    always_comb
    begin
        set_vec = 32'h0000_0000;
        set_vec[`TEF_BIT_SLV_DONE] = core_evt.slv_done;
        set_vec[`TEF_BIT_ARB_LOST] = arb_set;
        set_vec[`TEF_BIT_BUS_ERR] = bus_error_flag_set;
        set_vec[`TEF_BIT_MST_NOSTOP] = core_evt.mst_done && !core_evt.mst_stop_req;
        // write one clears, byte lanes honoured
        clr_vec = 32'h0000_0000;
        if (wr_commit && wb_req.adr == `TEF_OFS_CLEAR)
        begin
            clr_vec = wb_req.dat & {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}},
                                    {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
        end
        nxt_mask = mask_ff;
        if (wr_commit && wb_req.adr == `TEF_OFS_MASK)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (wb_req.sel[b])
                begin
                    nxt_mask[b*8 +: 8] = wb_req.dat[b*8 +: 8] & impl_bits[b*8 +: 8];
                end
            end
        end
    end

    // set wins over clear; reserved bits stay zero
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++)
        begin : g_flag
            if (impl_bits[gi])
            begin : g_impl
                assign nxt_raw[gi] = (raw_ff[gi] && !clr_vec[gi]) || set_vec[gi];
            end
            else
            begin : g_rsvd
                assign nxt_raw[gi] = 1'b0;
            end
        end
    endgenerate

    always_comb
    begin
        nxt_tag = tag_ff;
        if (arb_set)
        begin
            nxt_tag = `TEF_TAG_ARB_LOST;
        end
        if (bus_error_flag_set)
        begin
            nxt_tag = `TEF_TAG_BUS_ERR;
        end
        // stretch while slave-done or no-stop pends
        nxt_stretch = nxt_raw[`TEF_BIT_SLV_DONE] || nxt_raw[`TEF_BIT_MST_NOSTOP];
        nxt_mabort = bus_error_flag_set && core_evt.mst_active;
        nxt_sabort = bus_error_flag_set && !core_evt.mst_active && core_evt.slv_active;
        nxt_arb = arb_ff;
        unique case (arb_ff)
            ARB_IDLE: if (arb_set) nxt_arb = ARB_WAIT_STOP;
            ARB_WAIT_STOP: if (stop_det) nxt_arb = ARB_RETRY;
            ARB_RETRY: nxt_arb = ARB_IDLE;
            default: nxt_arb = ARB_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            raw_ff <= `TEF_RST_RAW;
            mask_ff <= `TEF_RST_MASK;
            dat_ff <= 32'h0000_0000;
            ack_ff <= 1'b0;
            tag_ff <= `TEF_TAG_NONE;
            stretch_ff <= 1'b0;
            mabort_ff <= 1'b0;
            sabort_ff <= 1'b0;
            arb_ff <= ARB_IDLE;
        end
        else if (ce)
        begin
            raw_ff <= nxt_raw;
            mask_ff <= nxt_mask;
            dat_ff <= nxt_dat;
            ack_ff <= nxt_ack;
            tag_ff <= nxt_tag;
            stretch_ff <= nxt_stretch;
            mabort_ff <= nxt_mabort;
            sabort_ff <= nxt_sabort;
            arb_ff <= nxt_arb;
        end
    end

    assign wb_dat_o = dat_ff;
    assign wb_ack_o = ack_ff;
    assign error_tag = tag_ff;
    // clock held low by open drain
    assign scl_out = 1'b0;
    assign scl_oe = stretch_ff;
    assign mst_start_ok = !stretch_ff;
    assign slv_notify_ok = !stretch_ff;
    // no stop after transfer without stop
    assign stop_inhibit = raw_ff[`TEF_BIT_MST_NOSTOP];
    assign mst_leave_bus = (arb_ff != ARB_IDLE);
    assign mst_retry = (arb_ff == ARB_RETRY);
    assign bus_error_flag_mst_abort = mabort_ff;
    assign bus_error_flag_slv_abort = sabort_ff;
    assign irq = |masked;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    slave_done_set_a: assert property (ce && core_evt.slv_done
        |=> raw_ff[`TEF_BIT_SLV_DONE])
        else $error("slave done event not flagged");

    stretch_hold_a: assert property (raw_ff[`TEF_BIT_SLV_DONE]
        |-> scl_oe && !mst_start_ok && !slv_notify_ok)
        else $error("clock not stretched while slave done pends");

    idle_free_a: assert property (!raw_ff[`TEF_BIT_SLV_DONE] && !raw_ff[`TEF_BIT_MST_NOSTOP]
        |-> !scl_oe && mst_start_ok && slv_notify_ok)
        else $error("clock or commands held without pending flag");

    arb_lost_tag_a: assert property (ce && arb_set && !bus_error_flag_set
        |=> raw_ff[`TEF_BIT_ARB_LOST] && error_tag == `TEF_TAG_ARB_LOST)
        else $error("arbitration loss not flagged with tag");

    arb_retry_a: assert property (ce && arb_ff == ARB_WAIT_STOP && stop_det
        |=> mst_retry && mst_leave_bus)
        else $error("no retry after stop");

    wait_stop_a: assert property (ce && mst_leave_bus && !mst_retry && !stop_det
        |=> mst_leave_bus && !mst_retry)
        else $error("left bus early after arbitration loss");

    retry_once_a: assert property (ce && mst_retry
        |=> !mst_retry && !mst_leave_bus)
        else $error("retry held too long");

    arb_detect_a: assert property (ce && arb_ff == ARB_IDLE && core_evt.mst_release_hi && scl_s && !sda_s
        |=> arb_ff == ARB_WAIT_STOP)
        else $error("lost zero not detected");

    bus_err_tag_a: assert property (ce && bus_error_flag_set
        |=> raw_ff[`TEF_BIT_BUS_ERR] && error_tag == `TEF_TAG_BUS_ERR && (bus_error_flag_mst_abort || bus_error_flag_slv_abort))
        else $error("bus error not flagged");

    mst_abort_a: assert property (ce && bus_error_flag_set && core_evt.mst_active
        |=> bus_error_flag_mst_abort && !bus_error_flag_slv_abort)
        else $error("master transfer not aborted on bus error");

    slv_abort_a: assert property (ce && bus_error_flag_set && !core_evt.mst_active
        |=> bus_error_flag_slv_abort && !bus_error_flag_mst_abort)
        else $error("slave transfer not aborted on bus error");

    tag_hold_a: assert property (ce && !arb_set && !bus_error_flag_set
        |=> error_tag == $past(error_tag))
        else $error("error tag changed without error");

    nostop_set_a: assert property (ce && core_evt.mst_done && !core_evt.mst_stop_req
        |=> raw_ff[`TEF_BIT_MST_NOSTOP] && stop_inhibit ##0 scl_oe)
        else $error("no-stop completion not flagged");

    nostop_hold_a: assert property (raw_ff[`TEF_BIT_MST_NOSTOP] && !(ce && wr_commit)
        |=> stop_inhibit && !slv_notify_ok)
        else $error("stop driven before clear");

    nostop_stretch_a: assert property (raw_ff[`TEF_BIT_MST_NOSTOP]
        |-> scl_oe && !mst_start_ok && !slv_notify_ok)
        else $error("clock not stretched after no-stop completion");

    nostop_clear_a: assert property (ce && wr_commit && wb_req.adr == `TEF_OFS_CLEAR && wb_req.sel[3]
        && wb_req.dat[`TEF_BIT_MST_NOSTOP] && !(core_evt.mst_done && !core_evt.mst_stop_req)
        |=> !stop_inhibit)
        else $error("no-stop flag survived its clear");

    clear_one_a: assert property (ce && wr_commit && wb_req.adr == `TEF_OFS_CLEAR && wb_req.sel[3]
        && wb_req.dat[`TEF_BIT_ARB_LOST] && !arb_set |=> !raw_ff[`TEF_BIT_ARB_LOST])
        else $error("write one did not clear");

    slv_sticky_a: assert property (ce && raw_ff[`TEF_BIT_SLV_DONE]
        && !(wr_commit && wb_req.adr == `TEF_OFS_CLEAR && wb_req.sel[2] && wb_req.dat[`TEF_BIT_SLV_DONE])
        |=> raw_ff[`TEF_BIT_SLV_DONE])
        else $error("slave done lost without clear");

    slv_clear_a: assert property (ce && wr_commit && wb_req.adr == `TEF_OFS_CLEAR && wb_req.sel[2]
        && wb_req.dat[`TEF_BIT_SLV_DONE] && !core_evt.slv_done
        |=> !raw_ff[`TEF_BIT_SLV_DONE])
        else $error("slave done not cleared");

    raw_ro_a: assert property (ce && wr_commit && wb_req.adr == `TEF_OFS_RAW && set_vec == 32'h0000_0000
        |=> raw_ff == $past(raw_ff))
        else $error("write changed raw status");

    masked_read_a: assert property (ce && nxt_ack && wb_req.adr == `TEF_OFS_MASKED
        |=> wb_dat_o == $past(masked))
        else $error("masked read wrong");

    ack_answer_a: assert property (ce && wb_req.cyc && wb_req.stb && !wb_ack_o
        |=> wb_ack_o)
        else $error("request not acknowledged");

    ack_once_a: assert property (ce && wb_ack_o
        |=> !wb_ack_o)
        else $error("ack held too long");

    raw_read_a: assert property (ce && nxt_ack && wb_req.adr == `TEF_OFS_RAW
        |=> wb_dat_o == $past(raw_ff))
        else $error("raw read wrong");

    reserved_zero_a: assert property ((raw_ff & ~32'h1310_0000) == 32'h0 && irq == |(raw_ff & mask_ff))
        else $error("reserved raw bit set or irq mismatch");

    mask_impl_a: assert property ((mask_ff & ~`TEF_IMPL_BITS) == 32'h0000_0000)
        else $error("mask holds reserved bit");
endmodule // tef_event_flags
`default_nettype wire

/* tef_bus_peer.sv */
/*
 * model of the other stations on the two-wire bus.
 * assumes pull-ups on both lines and a dut that only stretches the clock.
 */
`default_nettype none
module tef_bus_peer
(
    // clock
    input wire logic sys_clk,
    // dut clock pull-down
    input wire logic scl_oe,
    input wire logic scl_out,
    // wired lines
    output logic scl_in,
    output logic sda_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic scl_low = 1'b0;
    logic sda_low = 1'b0;
    assign scl_in = !((scl_oe && !scl_out) || scl_low);
    assign sda_in = !sda_low;

    task lines(input logic scl_l, input logic sda_l);
        @(posedge sys_clk);
        scl_low <= scl_l;
        sda_low <= sda_l;
        repeat (6) @(posedge sys_clk);
    endtask
endmodule // tef_bus_peer
`default_nettype wire

/* tb.sv */
/*
 * testbench of the transaction event flags block.
 * assumes the design's header and package are compiled first.
 */
`include "tef_consts.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tef_pkg::*;
    logic sys_clk;
    logic arst_n;
    logic ce;
    tef_wb_req_s wb_req;
    tef_core_evt_s core_evt;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic mst_start_ok;
    logic slv_notify_ok;
    logic stop_inhibit;
    logic mst_leave_bus;
    logic mst_retry;
    logic bus_error_flag_mst_abort;
    logic bus_error_flag_slv_abort;
    logic [3:0] error_tag;
    logic scl_in;
    logic sda_in;
    logic scl_oe;
    logic scl_out;
    logic irq;
    logic [31:0] v;
    int n_fail = 0;
    int compares = 0;
    int n_retry = 0;
    int n_mab = 0;
    int n_sab = 0;
    int k;

    tef_event_flags u_tef_event_flags (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .wb_req(wb_req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_evt(core_evt), .mst_start_ok(mst_start_ok),
        .slv_notify_ok(slv_notify_ok), .stop_inhibit(stop_inhibit), .mst_leave_bus(mst_leave_bus),
        .mst_retry(mst_retry), .bus_error_flag_mst_abort(bus_error_flag_mst_abort), .bus_error_flag_slv_abort(bus_error_flag_slv_abort),
        .error_tag(error_tag), .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out), .scl_oe(scl_oe), .irq(irq));
    tef_bus_peer u_peer (.sys_clk(sys_clk), .scl_oe(scl_oe), .scl_out(scl_out), .scl_in(scl_in), .sda_in(sda_in));

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        if (mst_retry === 1'b1) n_retry++;
        if (bus_error_flag_mst_abort === 1'b1) n_mab++;
        if (bus_error_flag_slv_abort === 1'b1) n_sab++;
    end

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1);
        v = wb_dat_o;
        wb_req <= '0;
        chk("wb latency", n, 32'h2);
    endtask

    task rd(input string name, input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        chk(name, v, exp);
    endtask

    task set_evt(input tef_core_evt_s e);
        @(posedge sys_clk);
        core_evt <= e;
    endtask

    // irq, scl_oe, start_ok, notify_ok, stop_inhibit, leave_bus
    task outs(input logic [5:0] exp);
        @(negedge sys_clk);
        chk("outs", {26'h0, irq, scl_oe, mst_start_ok, slv_notify_ok, stop_inhibit, mst_leave_bus}, {26'h0, exp});
    endtask

    task t_reset;
        outs(6'b001100);
        rd("raw", `TEF_OFS_RAW, 32'h0);
        rd("mask", `TEF_OFS_MASK, 32'h0);
        rd("masked", `TEF_OFS_MASKED, 32'h0);
        rd("unmapped", 8'h10, 32'h0);
        @(posedge sys_clk);
        ce <= 1'b0;
        set_evt(6'b100000);
        set_evt(6'b000000);
        @(posedge sys_clk);
        ce <= 1'b1;
        outs(6'b001100);
        rd("frozen", `TEF_OFS_RAW, 32'h0);
        $display("test reset done");
    endtask

    task t_slave_done;
        set_evt(6'b100000);
        set_evt(6'b000000);
        outs(6'b010000);
        rd("raw", `TEF_OFS_RAW, 32'h0010_0000);
        rd("masked", `TEF_OFS_MASKED, 32'h0);
        wb(1'b1, `TEF_OFS_MASK, 32'hffff_ffff);
        rd("mask", `TEF_OFS_MASK, 32'h1310_0000);
        outs(6'b110000);
        rd("masked", `TEF_OFS_MASKED, 32'h0010_0000);
        wb(1'b1, `TEF_OFS_RAW, 32'h0);
        rd("raw ro", `TEF_OFS_RAW, 32'h0010_0000);
        wb(1'b0, `TEF_OFS_STATUS, 32'h0);
        chk("status", v, 32'h0);
        wb(1'b1, `TEF_OFS_CLEAR, 32'h0);
        rd("clear zero", `TEF_OFS_RAW, 32'h0010_0000);
        wb(1'b1, `TEF_OFS_CLEAR, 32'h0010_0000);
        rd("clear one", `TEF_OFS_RAW, 32'h0);
        outs(6'b001100);
        $display("test slave done finished");
    endtask

    task t_nostop;
        set_evt(6'b011000);
        set_evt(6'b000000);
        rd("with stop", `TEF_OFS_RAW, 32'h0);
        set_evt(6'b010000);
        set_evt(6'b000000);
        rd("no stop", `TEF_OFS_RAW, 32'h1000_0000);
        outs(6'b110010);
        wb(1'b1, `TEF_OFS_CLEAR, 32'h1000_0000);
        outs(6'b001100);
        $display("test no stop done");
    endtask

    task t_arb;
        set_evt(6'b000100);
        u_peer.lines(1'b1, 1'b0);
        u_peer.lines(1'b1, 1'b1);
        u_peer.lines(1'b0, 1'b1);
        set_evt(6'b000000);
        outs(6'b101101);
        rd("arb raw", `TEF_OFS_RAW, 32'h0100_0000);
        wb(1'b0, `TEF_OFS_STATUS, 32'h0);
        chk("arb tag", v & 32'hf, 32'h1);
        k = n_retry;
        u_peer.lines(1'b0, 1'b0);
        chk("retry", n_retry - k, 1);
        outs(6'b101100);
        wb(1'b1, `TEF_OFS_CLEAR, 32'h0100_0000);
        rd("arb clr", `TEF_OFS_RAW, 32'h0);
        $display("test arbitration done");
    endtask

    task t_bus_error_flag;
        k = n_mab;
        set_evt(6'b000010);
        u_peer.lines(1'b0, 1'b1);
        rd("bus_error_flag raw", `TEF_OFS_RAW, 32'h0200_0000);
        chk("bus_error_flag tag", {28'h0, error_tag}, 32'h2);
        chk("mst abort", n_mab - k, 1);
        set_evt(6'b000001);
        wb(1'b1, `TEF_OFS_CLEAR, 32'h0200_0000);
        k = n_sab;
        u_peer.lines(1'b0, 1'b0);
        chk("slv abort", n_sab - k, 1);
        set_evt(6'b000000);
        wb(1'b1, `TEF_OFS_CLEAR, 32'h0200_0000);
        rd("bus_error_flag clr", `TEF_OFS_RAW, 32'h0);
        $display("test bus error done");
    endtask

    task stop_test;
        $display("counts: %0d compares, %0d mismatches", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        arst_n = 1'b0;
        ce = 1'b1;
        wb_req = '0;
        core_evt = '0;
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_reset;
        t_slave_done;
        t_nostop;
        t_arb;
        t_bus_error_flag;
        stop_test;
    end

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        stop_test;
    end
endmodule // tb
`default_nettype wire
